// *** logic/hrab_pkg.sv ***
package hrab_pkg;
   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int ADDR_W = 11;
   localparam int DATA_W = 32;

   // ----------------------------------------
   // Register and map offsets
   // ----------------------------------------
   localparam logic [10:0] OFS_GROUP_BASE = 11'h000;
   localparam logic [10:0] OFS_DAC_BASE = 11'h004;
   localparam logic [10:0] OFS_SERVICE_REQ = 11'h008;
   localparam logic [10:0] OFS_INT_STATUS = 11'h00c;
   localparam logic [10:0] OFS_TX_SLOT_MAP = 11'h200;
   localparam logic [10:0] OFS_TX_SUB_MAP = 11'h280;
   localparam logic [10:0] OFS_TX_CHAN_CFG = 11'h380;
   localparam logic [10:0] OFS_RX_DELTA = 11'h200;
   localparam logic [10:0] OFS_RAM_END = 11'h600;
   localparam logic [10:0] OFS_GLOBAL_CFG = 11'h600;
   localparam logic [10:0] OFS_IQ_POINTER = 11'h604;
   localparam logic [10:0] OFS_IQ_LENGTH = 11'h608;
   localparam logic [10:0] OFS_GROUP_CFG = 11'h60c;
   localparam logic [10:0] OFS_PROTECT = 11'h610;
   localparam logic [10:0] OFS_MSG_LENGTH = 11'h614;
   localparam logic [10:0] OFS_PORT_CFG = 11'h618;
   localparam int GROUP_STRUCT_BYTES = 1564;
   localparam int GROUP_ALIGN_BYTES = 2048;
   localparam int GROUP_ALIGN_BITS = 11;

   // ----------------------------------------
   // Answers and reset values
   // ----------------------------------------
   localparam logic [31:0] DEAD_ACCESS = 32'hdeadacce;
   localparam logic [31:0] ALL_ONES = 32'hffffffff;
   localparam logic [31:0] RESET_WORD = 32'h00000000;

   // Host access path chosen by decode
   typedef enum logic [1:0] {
      HRAB_PATH_NONE = 2'b00,
      HRAB_PATH_HOSTREG = 2'b01,
      HRAB_PATH_RAM = 2'b11
   } hrab_path_t;
endpackage

// *** logic/hrab_register_bank.sv ***
module hrab_register_bank
   import hrab_pkg::*;
#(
   parameter int RAM_WORDS = 384
)
(
   input wire logic core_clk,
   input wire logic arst_n,
   // Host slave port, one word per access, single-cycle strobes
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [hrab_pkg::ADDR_W-1:0] host_addr,
   input wire logic [hrab_pkg::DATA_W-1:0] host_wdata,
   output logic [hrab_pkg::DATA_W-1:0] host_rdata,
   output logic host_rvalid,
   // Device state
   input wire logic any_channel_active,
   input wire logic transmit_line_clock_active,
   input wire logic receive_line_clock_active,
   input wire logic [31:0] int_status_in,
   input wire logic [7:0] clock_active_flags,
   // Descriptor DMA controller side of the map RAM
   input wire logic dma_ram_rd,
   input wire logic [8:0] dma_ram_index,
   output logic [hrab_pkg::DATA_W-1:0] dma_ram_rdata,
   // Service request and configuration outputs
   output logic service_req_pulse,
   output logic [31:0] service_req_word,
   output logic [31:0] group_base_word,
   output logic [31:0] dac_base_word,
   output logic [31:0] global_cfg_word,
   output logic [31:0] iq_pointer_word,
   output logic [31:0] iq_length_word,
   output logic [31:0] group_cfg_word,
   output logic [31:0] protect_word,
   output logic [31:0] msg_length_word,
   output logic [31:0] port_cfg_word,
   output logic access_violation
);
   import hrab_pkg::*;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   logic word_ok;
   logic hit_base;
   logic hit_dac;
   logic hit_sreq;
   logic hit_stat;
   logic hit_gcfg;
   logic hit_iqp;
   logic hit_iql;
   logic hit_grp;
   logic hit_prot;
   logic hit_msg;
   logic hit_port;
   logic hit_ram;
   logic lclk_ok;
   logic allowed_active;
   hrab_path_t path;
   logic [8:0] ram_index;

   assign word_ok = (host_addr[1:0] == 2'b00);
   // Offsets match the shared-memory structure exactly
   assign hit_base = word_ok && (host_addr == OFS_GROUP_BASE);
   assign hit_dac = word_ok && (host_addr == OFS_DAC_BASE);
   assign hit_sreq = word_ok && (host_addr == OFS_SERVICE_REQ);
   assign hit_stat = word_ok && (host_addr == OFS_INT_STATUS);
   assign hit_gcfg = word_ok && (host_addr == OFS_GLOBAL_CFG);
   assign hit_iqp = word_ok && (host_addr == OFS_IQ_POINTER);
   assign hit_iql = word_ok && (host_addr == OFS_IQ_LENGTH);
   assign hit_grp = word_ok && (host_addr == OFS_GROUP_CFG);
   assign hit_prot = word_ok && (host_addr == OFS_PROTECT);
   assign hit_msg = word_ok && (host_addr == OFS_MSG_LENGTH);
   assign hit_port = word_ok && (host_addr == OFS_PORT_CFG);
   // Transmit maps from 0x200, receive maps 0x200 higher, up to 0x600
   assign hit_ram = word_ok && (host_addr >= OFS_TX_SLOT_MAP) && (host_addr < OFS_RAM_END);
   assign ram_index = 9'(host_addr[10:2] - OFS_TX_SLOT_MAP[10:2]);

   // Both line clocks must run for map RAM traffic
   assign lclk_ok = transmit_line_clock_active && receive_line_clock_active;

   // Only these are safe once a channel runs; others risk DMA lock-up
   assign allowed_active = hit_base || hit_sreq || hit_stat;
   assign access_violation = any_channel_active && (host_wr || host_rd) && !allowed_active;

   assign path = hit_ram ? HRAB_PATH_RAM
               : (hit_base || hit_dac || hit_sreq || hit_stat || hit_gcfg || hit_iqp || hit_iql
                  || hit_grp || hit_prot || hit_msg || hit_port) ? HRAB_PATH_HOSTREG
               : HRAB_PATH_NONE;

   // ----------------------------------------
   // Host interface registers
   // ----------------------------------------
   logic [31:0] base_reg;
   logic [31:0] dac_reg;
   logic [31:0] sreq_reg;
   logic [31:0] gcfg_reg;
   logic [31:0] iqp_reg;
   logic [31:0] iql_reg;
   logic [31:0] grp_reg;
   logic [31:0] prot_reg;
   logic [31:0] msg_reg;
   logic [31:0] port_reg;
   logic sreq_pulse_reg;
   logic wr_go;
   // Per-register write strobes
   logic wr_base;
   logic wr_dac;
   logic wr_sreq;
   logic wr_gcfg;
   logic wr_iqp;
   logic wr_iql;
   logic wr_grp;
   logic wr_prot;
   logic wr_msg;
   logic wr_port;

   // Writes are dropped while gated by channel activity (device-wide)
   assign wr_go = host_wr && (!any_channel_active || allowed_active);

   // One write enable per register, straight from the decode; no DMA involvement
   assign wr_base = wr_go && hit_base;
   assign wr_dac = wr_go && hit_dac;
   assign wr_sreq = wr_go && hit_sreq;
   assign wr_gcfg = wr_go && hit_gcfg;
   assign wr_iqp = wr_go && hit_iqp;
   assign wr_iql = wr_go && hit_iql;
   assign wr_grp = wr_go && hit_grp;
   assign wr_prot = wr_go && hit_prot;
   assign wr_msg = wr_go && hit_msg;
   assign wr_port = wr_go && hit_port;

   // Base pointer keeps 2 kB alignment; low bits read-only zero
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         base_reg <= RESET_WORD;
      else if (wr_base)
         base_reg <= {host_wdata[31:GROUP_ALIGN_BITS], {GROUP_ALIGN_BITS{1'b0}}};
   end

   // Dual address cycle base, plain read and write
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         dac_reg <= RESET_WORD;
      else if (wr_dac)
         dac_reg <= host_wdata;
   end

   // Service request word, write-only from the host view
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         sreq_reg <= RESET_WORD;
      else if (wr_sreq)
         sreq_reg <= host_wdata;
   end

   // Clock activity bits are read-only, writes to them ignored
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         gcfg_reg <= RESET_WORD;
      else if (wr_gcfg)
         gcfg_reg <= {host_wdata[31:8], 8'h00};
   end

   // Interrupt queue pointer
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         iqp_reg <= RESET_WORD;
      else if (wr_iqp)
         iqp_reg <= host_wdata;
   end

   // Interrupt queue length
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         iql_reg <= RESET_WORD;
      else if (wr_iql)
         iql_reg <= host_wdata;
   end

   // Group configuration
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         grp_reg <= RESET_WORD;
      else if (wr_grp)
         grp_reg <= host_wdata;
   end

   // Memory protection
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         prot_reg <= RESET_WORD;
      else if (wr_prot)
         prot_reg <= host_wdata;
   end

   // Message length limits
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         msg_reg <= RESET_WORD;
      else if (wr_msg)
         msg_reg <= host_wdata;
   end

   // Port configuration
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         port_reg <= RESET_WORD;
      else if (wr_port)
         port_reg <= host_wdata;
   end

   // Request strobe to the service engine, one cycle per accepted write
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         sreq_pulse_reg <= 1'b0;
      else
         sreq_pulse_reg <= wr_sreq;
   end

   // ----------------------------------------
   // Internal map RAM behind the DMA controller
   // ----------------------------------------
   logic [31:0] map_ram [RAM_WORDS];
   logic ram_wr;
   logic [31:0] ram_q_reg;
   logic [31:0] dma_q_reg;

   // Dead line clocks discard writes; stored content stays put
   assign ram_wr = wr_go && hit_ram && lclk_ok;

   // Plain array, no reset, so it can map to a memory macro
   always_ff @(posedge core_clk)
   begin
      if (ram_wr)
         map_ram[ram_index] <= host_wdata;
      ram_q_reg <= map_ram[ram_index];
      // Controller word only moves on its own read strobe
      if (dma_ram_rd)
         dma_q_reg <= map_ram[dma_ram_index];
   end
   assign dma_ram_rdata = dma_q_reg;

   // ----------------------------------------
   // Read answer, one cycle after the strobe
   // ----------------------------------------
   logic rd_hold_reg;
   hrab_path_t path_reg;
   logic dead_reg;
   logic rd_block_reg;
   logic [31:0] reg_q_reg;
   logic [31:0] reg_mux;

   // Service request word is write-only from the host view
   assign reg_mux = hit_base ? base_reg
                  : hit_dac ? dac_reg
                  : hit_stat ? int_status_in
                  : hit_gcfg ? {gcfg_reg[31:8], clock_active_flags}
                  : hit_iqp ? iqp_reg
                  : hit_iql ? iql_reg
                  : hit_grp ? grp_reg
                  : hit_prot ? prot_reg
                  : hit_msg ? msg_reg
                  : hit_port ? port_reg
                  : ALL_ONES;

   // Capture what the answer needs in the strobe cycle
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rd_hold_reg <= 1'b0;
         path_reg <= HRAB_PATH_NONE;
         dead_reg <= 1'b0;
         rd_block_reg <= 1'b0;
         reg_q_reg <= RESET_WORD;
      end
      else
      begin
         rd_hold_reg <= host_rd;
         path_reg <= path;
         dead_reg <= !lclk_ok;
         rd_block_reg <= any_channel_active && !allowed_active;
         reg_q_reg <= reg_mux;
      end
   end

   logic [31:0] rdata_next;
   // Gated reads get all ones rather than risk a stale word
   assign rdata_next = (rd_block_reg || path_reg == HRAB_PATH_NONE) ? ALL_ONES
                     : (path_reg == HRAB_PATH_RAM) ? (dead_reg ? DEAD_ACCESS : ram_q_reg)
                     : reg_q_reg;

   assign host_rdata = rd_hold_reg ? rdata_next : RESET_WORD;
   assign host_rvalid = rd_hold_reg;

   // ----------------------------------------
   // Outputs to the service engine
   // ----------------------------------------
   assign service_req_pulse = sreq_pulse_reg;
   assign service_req_word = sreq_reg;
   assign group_base_word = base_reg;
   assign dac_base_word = dac_reg;
   assign global_cfg_word = gcfg_reg;
   assign iq_pointer_word = iqp_reg;
   assign iq_length_word = iql_reg;
   assign group_cfg_word = grp_reg;
   assign protect_word = prot_reg;
   assign msg_length_word = msg_reg;
   assign port_cfg_word = port_reg;
endmodule

// *** tb/hrab_host_model.sv ***
module hrab_host_model
   import hrab_pkg::*;
(
   input wire logic core_clk,
   output logic host_wr,
   output logic host_rd,
   output logic [hrab_pkg::ADDR_W-1:0] host_addr,
   output logic [hrab_pkg::DATA_W-1:0] host_wdata,
   input wire logic [hrab_pkg::DATA_W-1:0] host_rdata,
   input wire logic host_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial
   begin
      host_wr = 1'b0;
      host_rd = 1'b0;
      host_addr = 11'h7ff;
      host_wdata = 32'h0;
   end
   // One-cycle write strobe; released lines show the inverse, not the old word
   task automatic wr(input logic [10:0] a, input logic [31:0] d);
      @(posedge core_clk);
      #1;
      host_wr = 1'b1;
      host_addr = a;
      host_wdata = d;
      @(posedge core_clk);
      #1;
      host_wr = 1'b0;
      host_addr = ~a;
      host_wdata = ~d;
   endtask
   // Answer taken just after the edge that raises rvalid, while it stands
   task automatic rd(input logic [10:0] a, output logic [31:0] d);
      @(posedge core_clk);
      #1;
      host_rd = 1'b1;
      host_addr = a;
      @(posedge core_clk);
      #1;
      host_rd = 1'b0;
      host_addr = ~a;
      d = (host_rvalid === 1'b1) ? host_rdata : 32'hxxxxxxxx;
   endtask
endmodule

// *** tb/hrab_monitor.sv ***
module hrab_monitor
   import hrab_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [hrab_pkg::ADDR_W-1:0] host_addr,
   input wire logic [hrab_pkg::DATA_W-1:0] host_wdata,
   input wire logic [hrab_pkg::DATA_W-1:0] host_rdata,
   input wire logic host_rvalid,
   input wire logic any_channel_active,
   input wire logic transmit_line_clock_active,
   input wire logic receive_line_clock_active,
   input wire logic service_req_pulse,
   input wire logic [31:0] service_req_word,
   input wire logic [31:0] group_base_word,
   input wire logic [31:0] iq_pointer_word,
   input wire logic access_violation
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // Address classes
   wire ram_hit = host_addr[1:0] == 2'b00 && host_addr >= OFS_TX_SLOT_MAP && host_addr < OFS_RAM_END;
   wire open_hit = host_addr == OFS_GROUP_BASE || host_addr == OFS_SERVICE_REQ || host_addr == OFS_INT_STATUS;
   wire clk_ok = transmit_line_clock_active && receive_line_clock_active;
   rd_answer_a: assert property (host_rd |=> host_rvalid) else $error("read not answered");
   rd_idle_a: assert property (!host_rd |=> !host_rvalid && host_rdata == 32'h0) else $error("stray answer");
   dead_read_a: assert property (host_rd && ram_hit && !any_channel_active && !clk_ok
      |=> host_rdata == DEAD_ACCESS) else $error("no dead pattern");
   wo_read_a: assert property (host_rd && host_addr == OFS_SERVICE_REQ |=> host_rdata == ALL_ONES)
      else $error("write-only read");
   locked_read_a: assert property (host_rd && any_channel_active && !open_hit |=> host_rdata == ALL_ONES)
      else $error("locked read");
   req_pulse_a: assert property (host_wr && host_addr == OFS_SERVICE_REQ
      |=> service_req_pulse && service_req_word == $past(host_wdata)) else $error("request lost");
   base_align_a: assert property (group_base_word[10:0] == 11'h0) else $error("base unaligned");
   base_write_a: assert property (host_wr && host_addr == OFS_GROUP_BASE
      |=> group_base_word[31:11] == $past(host_wdata[31:11])) else $error("base not written");
   locked_drop_a: assert property (host_wr && any_channel_active && host_addr == OFS_IQ_POINTER
      |=> $stable(iq_pointer_word)) else $error("locked write taken");
   violation_flag_a: assert property (access_violation == ((host_wr || host_rd) && any_channel_active && !open_hit))
      else $error("violation flag");
   cover property (host_rd ##1 host_rdata == DEAD_ACCESS);
   cover property (service_req_pulse);
   cover property (access_violation);
endmodule
bind hrab_register_bank hrab_monitor u_mon (.core_clk, .arst_n, .host_wr, .host_rd, .host_addr, .host_wdata,
   .host_rdata, .host_rvalid, .any_channel_active, .transmit_line_clock_active, .receive_line_clock_active,
   .service_req_pulse, .service_req_word, .group_base_word, .iq_pointer_word, .access_violation);

// *** tb/tb_top.sv ***
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
   $display("wrong value at %0t ns: got %h expected %h", $time, g, e); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import hrab_pkg::*;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic any_channel_active = 1'b0;
   logic transmit_line_clock_active = 1'b1;
   logic receive_line_clock_active = 1'b1;
   logic [31:0] int_status_in = 32'hc0de0001;
   logic [7:0] clock_active_flags = 8'h5a;
   logic dma_ram_rd = 1'b0;
   logic [8:0] dma_ram_index = 9'h0;
   wire logic host_wr, host_rd, host_rvalid;
   wire logic [10:0] host_addr;
   wire logic [31:0] host_wdata, host_rdata, dma_ram_rdata, service_req_word;
   wire logic service_req_pulse;
   wire logic [31:0] group_base_word, dac_base_word, global_cfg_word, iq_pointer_word, iq_length_word;
   wire logic [31:0] group_cfg_word, protect_word, msg_length_word, port_cfg_word;
   int failures = 0;
   int check_count = 0;
   int cyc = 0;
   logic [31:0] v;
   logic [10:0] regs [7] = '{OFS_DAC_BASE, OFS_IQ_POINTER, OFS_IQ_LENGTH, OFS_GROUP_CFG, OFS_PROTECT,
      OFS_MSG_LENGTH, OFS_PORT_CFG};
   always #20 core_clk = ~core_clk;
   hrab_host_model u_host (.core_clk, .host_wr, .host_rd, .host_addr, .host_wdata, .host_rdata, .host_rvalid);
   hrab_register_bank #(.RAM_WORDS(384)) u_dut (.core_clk, .arst_n, .host_wr, .host_rd, .host_addr, .host_wdata,
      .host_rdata, .host_rvalid, .any_channel_active, .transmit_line_clock_active, .receive_line_clock_active,
      .int_status_in, .clock_active_flags, .dma_ram_rd, .dma_ram_index, .dma_ram_rdata, .service_req_pulse,
      .service_req_word, .group_base_word, .dac_base_word, .global_cfg_word, .iq_pointer_word,
      .iq_length_word, .group_cfg_word, .protect_word, .msg_length_word, .port_cfg_word,
      .access_violation());
   // Read and compare in one call
   task automatic rc(input logic [10:0] a, input logic [31:0] e);
      u_host.rd(a, v);
      `CHK(v, e)
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Hang guard, well above the roughly 85 cycles the tests need
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         failures++;
         end_of_test;
      end
   end
   initial
   begin
      #61 arst_n = 1'b1;
      rc(OFS_IQ_POINTER, RESET_WORD);
      foreach (regs[i])
      begin
         u_host.wr(regs[i], 32'ha5c30000 | 32'(regs[i]));
         rc(regs[i], 32'ha5c30000 | 32'(regs[i]));
      end
      `CHK(dac_base_word, 32'ha5c30004)
      `CHK(iq_pointer_word, 32'ha5c30604)
      `CHK(iq_length_word, 32'ha5c30608)
      `CHK(group_cfg_word, 32'ha5c3060c)
      `CHK(protect_word, 32'ha5c30610)
      `CHK(msg_length_word, 32'ha5c30614)
      `CHK(port_cfg_word, 32'ha5c30618)
      u_host.wr(11'h606, 32'h0);
      rc(OFS_IQ_POINTER, 32'ha5c30604);
      u_host.wr(OFS_GLOBAL_CFG, 32'h123456ff);
      `CHK(global_cfg_word, 32'h12345600)
      rc(OFS_GLOBAL_CFG, 32'h1234565a);
      u_host.wr(OFS_GROUP_BASE, 32'h00123fff);
      `CHK(group_base_word, 32'h00123800)
      rc(OFS_GROUP_BASE, 32'h00123800);
      u_host.wr(OFS_SERVICE_REQ, 32'h00000a01);
      `CHK(service_req_pulse, 1'b1)
      `CHK(service_req_word, 32'h00000a01)
      rc(OFS_SERVICE_REQ, ALL_ONES);
      `CHK(service_req_pulse, 1'b0)
      u_host.wr(11'h020, 32'h0);
      rc(11'h020, ALL_ONES);
      rc(11'h602, ALL_ONES);
      u_host.wr(OFS_INT_STATUS, 32'h0);
      rc(OFS_INT_STATUS, 32'hc0de0001);
      done("registers");
      u_host.wr(OFS_TX_SLOT_MAP, 32'h11112222);
      u_host.wr(OFS_RAM_END - 11'h004, 32'h33334444);
      rc(OFS_RAM_END - 11'h004, 32'h33334444);
      @(posedge core_clk);
      #1 dma_ram_rd = 1'b1;
      @(posedge core_clk);
      #1 dma_ram_rd = 1'b0;
      `CHK(dma_ram_rdata, 32'h11112222)
      transmit_line_clock_active = 1'b0;
      rc(OFS_TX_SLOT_MAP, DEAD_ACCESS);
      transmit_line_clock_active = 1'b1;
      receive_line_clock_active = 1'b0;
      u_host.wr(OFS_TX_SLOT_MAP, 32'h0);
      receive_line_clock_active = 1'b1;
      rc(OFS_TX_SLOT_MAP, 32'h11112222);
      done("map ram");
      any_channel_active = 1'b1;
      rc(OFS_IQ_POINTER, ALL_ONES);
      u_host.wr(OFS_IQ_POINTER, 32'h0);
      rc(OFS_INT_STATUS, 32'hc0de0001);
      u_host.wr(OFS_GROUP_BASE, 32'h00200000);
      rc(OFS_GROUP_BASE, 32'h00200000);
      any_channel_active = 1'b0;
      rc(OFS_IQ_POINTER, 32'ha5c30604);
      done("active");
      end_of_test;
   end
endmodule
